// ===== common/fssp_cfg.svh
// Constants for the fuse, signature and serial programming block.
`ifndef FSSP_CFG_SVH
`define FSSP_CFG_SVH
// ----------------------------------------------------------------------
// Fuse reset values and field positions.
// ----------------------------------------------------------------------
`define FSSP_FUSE_HI_RST 8'hFF
`define FSSP_FUSE_LO_RST 8'h6A
`define FSSP_SELF_PROGRAM_ENABLE 4
`define FSSP_ONCHIP_DEBUG_ENABLE 3
`define FSSP_BROWNOUT_LEVEL_HI 2
`define FSSP_BROWNOUT_LEVEL_LO 1
`define FSSP_EXT_RESET_DISABLE 0
`define FSSP_SERIAL_PROG_ENABLE 7
`define FSSP_EEPROM_PRESERVE 6
`define FSSP_WATCHDOG_ALWAYS_ON 5
`define FSSP_CLOCK_DIVIDE_BY_EIGHT 4
`define FSSP_STARTUP_TIME_SEL_HI 3
`define FSSP_STARTUP_TIME_SEL_LO 2
`define FSSP_CLOCK_SOURCE_SEL_HI 1
`define FSSP_CLOCK_SOURCE_SEL_LO 0
`define FSSP_LOCK_RST 2'h3
// ----------------------------------------------------------------------
// Signature and calibration bytes; the values are arbitrary.
// ----------------------------------------------------------------------
`define FSSP_SIG_ADDR0 2'h0
`define FSSP_SIG_ADDR1 2'h1
`define FSSP_SIG_ADDR2 2'h2
`define FSSP_SIG_BYTE0 8'hA5
`define FSSP_SIG_BYTE1 8'h5A
`define FSSP_SIG_BYTE2 8'h3C
`define FSSP_CAL_BYTE 8'h80
// ----------------------------------------------------------------------
// Memory geometry.
// ----------------------------------------------------------------------
`define FSSP_FLASH_WORDS 512
`define FSSP_PAGE_WORDS 16
`define FSSP_EE_BYTES 64
`define FSSP_ERASE_LAST 9'h1FF
// ----------------------------------------------------------------------
// Serial instruction codes.
// ----------------------------------------------------------------------
`define FSSP_OP_GROUP 8'hAC
`define FSSP_OP_ENABLE 8'h53
`define FSSP_OP_ERASE 3'h4
`define FSSP_OP_WR_LOCK 3'h7
`define FSSP_OP_WR_FUSE_LO 8'hA0
`define FSSP_OP_WR_FUSE_HI 8'hA8
`define FSSP_OP_RD_PROG_LO 8'h20
`define FSSP_OP_RD_PROG_HI 8'h28
`define FSSP_OP_LD_PAGE_LO 8'h40
`define FSSP_OP_LD_PAGE_HI 8'h48
`define FSSP_OP_WR_PAGE 8'h4C
`define FSSP_OP_RD_EE 8'hA0
`define FSSP_OP_WR_EE 8'hC0
`define FSSP_OP_RD_LOCK 8'h58
`define FSSP_OP_RD_FUSE_LO 8'h50
`define FSSP_SUB_FUSE_HI 8'h08
`define FSSP_OP_RD_SIG 8'h30
`define FSSP_OP_RD_CAL 8'h38
`define FSSP_OP_POLL 8'hF0
`endif

// ===== common/fssp_pkg.sv
// Types shared by the fuse and serial programming block.
package fssp_pkg;
  typedef enum logic [0:0] {
    FSSP_IDLE = 1'b0,
    FSSP_ERASE = 1'b1
  } fssp_state_t;
endpackage : fssp_pkg

// ===== src/fssp_shift.sv
// Serial byte shifter for the programming link.
`timescale 1ns/10ps
`include "fssp_cfg.svh"
module fssp_shift (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Link pins; link_en low holds the framing idle.
  input wire logic link_en,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Byte side.
  input wire logic [7:0] tx_byte,
  output logic byte_done,
  output logic [1:0] byte_idx,
  output logic [7:0] rx_byte
);
  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic sck_q_ff, nxt_sck_q;
  logic [2:0] bit_ff, nxt_bit;
  logic [1:0] idx_ff, nxt_idx;
  logic [7:0] sh_ff, nxt_sh;
  logic done_ff, nxt_done;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] tx_ff, nxt_tx;
  logic miso_ff, nxt_miso;
  logic sck_rise;
  logic sck_fall;

  // Edge detection; phases span several clocks so no edge is missed.
  assign sck_rise = sck && !sck_q_ff;
  assign sck_fall = !sck && sck_q_ff;

  // Next-state logic: sample on the rising edge, shift out on the falling.
  always_comb begin
    nxt_sck_q = sck;
    nxt_bit = bit_ff;
    nxt_idx = idx_ff;
    nxt_sh = sh_ff;
    nxt_done = 1'b0;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_miso = miso_ff;
    if (!link_en) begin
      nxt_bit = 3'h0;
      nxt_idx = 2'h0;
      nxt_miso = 1'b0;
    end else begin
      if (done_ff) begin
        nxt_tx = tx_byte;
        nxt_idx = idx_ff + 2'h1;
      end
      if (sck_rise) begin
        nxt_sh = {sh_ff[6:0], mosi};
        nxt_bit = bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
          nxt_done = 1'b1;
          nxt_rx = {sh_ff[6:0], mosi};
        end
      end
      if (sck_fall) begin
        if (bit_ff == 3'h0) begin
          nxt_miso = tx_ff[7];
          nxt_tx = {tx_ff[6:0], 1'b0};
        end else begin
          nxt_miso = tx_ff[7];
          nxt_tx = {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Registers.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q_ff <= 1'b0;
      bit_ff <= 3'h0;
      idx_ff <= 2'h0;
      sh_ff <= 8'h00;
      done_ff <= 1'b0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      miso_ff <= 1'b0;
    end else begin
      sck_q_ff <= nxt_sck_q;
      bit_ff <= nxt_bit;
      idx_ff <= nxt_idx;
      sh_ff <= nxt_sh;
      done_ff <= nxt_done;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      miso_ff <= nxt_miso;
    end
  end

  assign miso = miso_ff;
  assign byte_done = done_ff;
  assign byte_idx = idx_ff;
  assign rx_byte = rx_ff;

  // While the link stays enabled, output only moves in the cycle after a falling edge of the serial clock is seen.
  property p_miso_hold;
    @(posedge core_clk) disable iff (!rst_b)
    (link_en && $past(link_en) && !$past(sck_fall)) |-> $stable(miso_ff);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved off falling edge");
endmodule : fssp_shift

// ===== src/fssp_core.sv
// Fuse store, signature readout and serial programming engine.
`timescale 1ns/10ps
`include "fssp_cfg.svh"
module fssp_core (
  // Clock and power-up reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Programming pins.
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Static configuration.
  output logic cfg_self_program_enable,
  output logic cfg_onchip_debug_enable,
  output logic [1:0] cfg_brownout_level,
  output logic cfg_ext_reset_disable,
  output logic cfg_eeprom_preserve,
  output logic cfg_watchdog_always_on,
  output logic watchdog_irq_allow,
  output logic cfg_clock_divide_by_eight,
  output logic [1:0] cfg_startup_time_sel,
  output logic [1:0] cfg_clock_source_sel,
  output logic [7:0] oscillator_trim_register,
  // Status.
  output logic prog_mode,
  output logic nvm_busy
);
  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [7:0] nv_hi_ff, nxt_nv_hi;
  logic [7:0] nv_lo_ff, nxt_nv_lo;
  logic [7:0] act_hi_ff, nxt_act_hi;
  logic [7:0] act_lo_ff, nxt_act_lo;
  logic [1:0] lock_ff, nxt_lock;
  logic init_ff, prog_q_ff, pe_ff, nxt_pe, keep_ee_ff, nxt_keep_ee;
  logic [7:0] b0_ff, nxt_b0, b1_ff, nxt_b1, b2_ff, nxt_b2;
  logic [7:0] trim_ff, nxt_trim;
  logic [8:0] ers_cnt_ff, nxt_ers_cnt;
  fssp_pkg::fssp_state_t st_ff, nxt_st;
  logic [15:0] flash_mem [0:`FSSP_FLASH_WORDS-1];
  logic [7:0] ee_mem [0:`FSSP_EE_BYTES-1];
  logic [15:0] pbuf [0:`FSSP_PAGE_WORDS-1];
  logic byte_done, erasing, ee_erase, cmd_ok, fuse_wr_ok;
  logic [1:0] byte_idx;
  logic [7:0] rx_byte, tx_byte, rd_data;
  logic ee_we, pbuf_we_lo, pbuf_we_hi, page_we;

  // Fuse, EEPROM and flash page writes are allowed only while lock bit zero is set; chip erase is not gated.
  function automatic logic fssp_wr_ok(input logic [1:0] lock);
    fssp_wr_ok = lock[0];
  endfunction : fssp_wr_ok

  // Serial programming needs the enable fuse programmed and the reset pin kept.
  assign prog_mode = !reset_pin_n && !act_lo_ff[`FSSP_SERIAL_PROG_ENABLE]
    && act_hi_ff[`FSSP_EXT_RESET_DISABLE];
  assign miso_oe = prog_mode;
  assign erasing = (st_ff == fssp_pkg::FSSP_ERASE);
  assign nvm_busy = erasing;
  assign ee_erase = erasing && !keep_ee_ff && (ers_cnt_ff[8:6] == 3'h0);
  assign cmd_ok = byte_done && (byte_idx == 2'h3) && pe_ff && !erasing;
  assign fuse_wr_ok = cmd_ok && (b0_ff == `FSSP_OP_GROUP) && fssp_wr_ok(lock_ff);

  // ----------------------------------------------------------------------
  // Serial link.
  // ----------------------------------------------------------------------
  fssp_shift u_shift (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .link_en(prog_mode),
    .sck(sck),
    .mosi(mosi),
    .miso(miso),
    .tx_byte(tx_byte),
    .byte_done(byte_done),
    .byte_idx(byte_idx),
    .rx_byte(rx_byte)
  );

  // Read data for the fourth byte; byte three is still in rx_byte.
  always_comb begin
    rd_data = 8'h00;
    case (b0_ff)
      `FSSP_OP_RD_PROG_LO: rd_data = (lock_ff == 2'h0) ? 8'hFF
        : flash_mem[{b1_ff[0], rx_byte}][7:0];
      `FSSP_OP_RD_PROG_HI: rd_data = (lock_ff == 2'h0) ? 8'hFF
        : flash_mem[{b1_ff[0], rx_byte}][15:8];
      `FSSP_OP_RD_EE: rd_data = (lock_ff == 2'h0) ? 8'hFF : ee_mem[rx_byte[5:0]];
      `FSSP_OP_RD_LOCK: rd_data = (b1_ff == `FSSP_SUB_FUSE_HI) ? nv_hi_ff
        : {6'h3F, lock_ff};
      `FSSP_OP_RD_FUSE_LO: rd_data = nv_lo_ff;
      `FSSP_OP_RD_SIG: begin
        case (rx_byte[1:0])
          `FSSP_SIG_ADDR0: rd_data = `FSSP_SIG_BYTE0;
          `FSSP_SIG_ADDR1: rd_data = `FSSP_SIG_BYTE1;
          `FSSP_SIG_ADDR2: rd_data = `FSSP_SIG_BYTE2;
          default: rd_data = 8'h00;
        endcase
      end
      `FSSP_OP_RD_CAL: rd_data = `FSSP_CAL_BYTE;
      `FSSP_OP_POLL: rd_data = {7'h00, erasing};
      default: rd_data = 8'h00;
    endcase
  end

  // Byte to send next: echo during bytes two and three, read data in four.
  always_comb begin
    tx_byte = 8'h00;
    if (byte_idx == 2'h2) begin
      tx_byte = rd_data;
    end else if (byte_idx != 2'h3) begin
      tx_byte = rx_byte;
    end
  end

  // Memory write strobes decoded at the end of a frame.
  always_comb begin
    ee_we = cmd_ok && (b0_ff == `FSSP_OP_WR_EE) && fssp_wr_ok(lock_ff);
    pbuf_we_lo = cmd_ok && (b0_ff == `FSSP_OP_LD_PAGE_LO);
    pbuf_we_hi = cmd_ok && (b0_ff == `FSSP_OP_LD_PAGE_HI);
    page_we = cmd_ok && (b0_ff == `FSSP_OP_WR_PAGE) && fssp_wr_ok(lock_ff);
  end

  // ----------------------------------------------------------------------
  // Control state.
  // ----------------------------------------------------------------------
  // Next values for fuses, locks, command bytes and the erase sequencer.
  always_comb begin
    nxt_nv_hi = nv_hi_ff;
    nxt_nv_lo = nv_lo_ff;
    nxt_act_hi = act_hi_ff;
    nxt_act_lo = act_lo_ff;
    nxt_lock = lock_ff;
    nxt_pe = pe_ff;
    nxt_keep_ee = keep_ee_ff;
    nxt_b0 = b0_ff;
    nxt_b1 = b1_ff;
    nxt_b2 = b2_ff;
    nxt_ers_cnt = ers_cnt_ff;
    nxt_st = st_ff;
    nxt_trim = reset_pin_n ? trim_ff : `FSSP_CAL_BYTE;
    // Latch the fuses at power-up and at each entry to or exit from programming.
    if (init_ff || (prog_mode != prog_q_ff)) begin
      nxt_act_hi = nv_hi_ff;
      nxt_act_lo = nv_lo_ff;
    end
    if (byte_done) begin
      unique case (byte_idx)
        2'h0: nxt_b0 = rx_byte;
        2'h1: nxt_b1 = rx_byte;
        2'h2: nxt_b2 = rx_byte;
        2'h3: nxt_b2 = b2_ff;
      endcase
    end
    if (!prog_mode) begin
      nxt_pe = 1'b0;
    end else if (byte_done && (byte_idx == 2'h3) && (b0_ff == `FSSP_OP_GROUP)
        && (b1_ff == `FSSP_OP_ENABLE)) begin
      nxt_pe = 1'b1;
    end
    if (cmd_ok && (b0_ff == `FSSP_OP_GROUP)) begin
      if (b1_ff[7:5] == `FSSP_OP_ERASE) begin
        nxt_st = fssp_pkg::FSSP_ERASE;
        nxt_ers_cnt = 9'h000;
        nxt_keep_ee = !nv_lo_ff[`FSSP_EEPROM_PRESERVE];
        nxt_lock = `FSSP_LOCK_RST;
      end else if (b1_ff[7:5] == `FSSP_OP_WR_LOCK) begin
        nxt_lock = lock_ff & rx_byte[1:0];
      end
    end
    if (fuse_wr_ok && (b1_ff == `FSSP_OP_WR_FUSE_LO)) begin
      nxt_nv_lo = {nv_lo_ff[`FSSP_SERIAL_PROG_ENABLE], rx_byte[6:0]};
    end
    if (fuse_wr_ok && (b1_ff == `FSSP_OP_WR_FUSE_HI)) begin
      nxt_nv_hi = rx_byte;
    end
    unique case (st_ff)
      fssp_pkg::FSSP_IDLE: nxt_ers_cnt = nxt_ers_cnt;
      fssp_pkg::FSSP_ERASE: begin
        nxt_ers_cnt = ers_cnt_ff + 9'h001;
        if (ers_cnt_ff == `FSSP_ERASE_LAST) begin
          nxt_st = fssp_pkg::FSSP_IDLE;
        end
      end
    endcase
  end

  // Control registers; fuse store powers up at the unprogrammed defaults.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_hi_ff <= `FSSP_FUSE_HI_RST;
      nv_lo_ff <= `FSSP_FUSE_LO_RST;
      act_hi_ff <= `FSSP_FUSE_HI_RST;
      act_lo_ff <= `FSSP_FUSE_LO_RST;
      lock_ff <= `FSSP_LOCK_RST;
      init_ff <= 1'b1;
      prog_q_ff <= 1'b0;
      pe_ff <= 1'b0;
      keep_ee_ff <= 1'b0;
      b0_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      trim_ff <= `FSSP_CAL_BYTE;
      ers_cnt_ff <= 9'h000;
      st_ff <= fssp_pkg::FSSP_IDLE;
    end else begin
      nv_hi_ff <= nxt_nv_hi;
      nv_lo_ff <= nxt_nv_lo;
      act_hi_ff <= nxt_act_hi;
      act_lo_ff <= nxt_act_lo;
      lock_ff <= nxt_lock;
      init_ff <= 1'b0;
      prog_q_ff <= prog_mode;
      pe_ff <= nxt_pe;
      keep_ee_ff <= nxt_keep_ee;
      b0_ff <= nxt_b0;
      b1_ff <= nxt_b1;
      b2_ff <= nxt_b2;
      trim_ff <= nxt_trim;
      ers_cnt_ff <= nxt_ers_cnt;
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Memory arrays.
  // ----------------------------------------------------------------------
  // Erase walks one word per clock; page write commits the whole buffer.
  always_ff @(posedge core_clk) begin
    if (erasing) begin
      flash_mem[ers_cnt_ff] <= 16'hFFFF;
    end
    if (ee_erase) begin
      ee_mem[ers_cnt_ff[5:0]] <= 8'hFF;
    end
    if (ee_we) begin
      ee_mem[b2_ff[5:0]] <= rx_byte;
    end
    if (pbuf_we_lo) begin
      pbuf[b2_ff[3:0]][7:0] <= rx_byte;
    end
    if (pbuf_we_hi) begin
      pbuf[b2_ff[3:0]][15:8] <= rx_byte;
    end
    if (page_we) begin
      for (int i = 0; i < `FSSP_PAGE_WORDS; i++) begin
        flash_mem[{b1_ff[0], b2_ff[7:4], i[3:0]}] <= pbuf[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs from the latched fuses and the trim register; EEPROM preserve follows the stored fuse while programming.
  // ----------------------------------------------------------------------
  always_comb begin
    cfg_self_program_enable = act_hi_ff[`FSSP_SELF_PROGRAM_ENABLE];
    cfg_onchip_debug_enable = act_hi_ff[`FSSP_ONCHIP_DEBUG_ENABLE];
    cfg_brownout_level = {act_hi_ff[`FSSP_BROWNOUT_LEVEL_HI], act_hi_ff[`FSSP_BROWNOUT_LEVEL_LO]};
    cfg_ext_reset_disable = act_hi_ff[`FSSP_EXT_RESET_DISABLE];
    cfg_eeprom_preserve = prog_mode ? nv_lo_ff[`FSSP_EEPROM_PRESERVE]
      : act_lo_ff[`FSSP_EEPROM_PRESERVE];
    cfg_watchdog_always_on = act_lo_ff[`FSSP_WATCHDOG_ALWAYS_ON];
    watchdog_irq_allow = act_lo_ff[`FSSP_WATCHDOG_ALWAYS_ON];
    cfg_clock_divide_by_eight = act_lo_ff[`FSSP_CLOCK_DIVIDE_BY_EIGHT];
    cfg_startup_time_sel = {act_lo_ff[`FSSP_STARTUP_TIME_SEL_HI],
      act_lo_ff[`FSSP_STARTUP_TIME_SEL_LO]};
    cfg_clock_source_sel = {act_lo_ff[`FSSP_CLOCK_SOURCE_SEL_HI],
      act_lo_ff[`FSSP_CLOCK_SOURCE_SEL_LO]};
    oscillator_trim_register = trim_ff;
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  property p_serial_prog_enable_frozen;
    @(posedge core_clk) disable iff (!rst_b)
    prog_q_ff |=> $stable(nv_lo_ff[`FSSP_SERIAL_PROG_ENABLE]);
  endproperty
  a_serial_prog_enable_frozen: assert property (p_serial_prog_enable_frozen) else $error("enable fuse changed");

  property p_lock_fuse;
    @(posedge core_clk) disable iff (!rst_b)
    !lock_ff[0] |=> $stable(nv_lo_ff) && $stable(nv_hi_ff);
  endproperty
  a_lock_fuse: assert property (p_lock_fuse) else $error("fuse written while locked");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!rst_b)
    (prog_mode && prog_q_ff && !init_ff) |=> $stable(act_lo_ff) && $stable(act_hi_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fuses applied in session");

  property p_erase_fuse;
    @(posedge core_clk) disable iff (!rst_b)
    erasing |=> $stable(nv_lo_ff) && $stable(nv_hi_ff);
  endproperty
  a_erase_fuse: assert property (p_erase_fuse) else $error("erase touched fuses");

  property p_erase_done;
    @(posedge core_clk) disable iff (!rst_b)
    $fell(erasing) |-> (flash_mem[0] == 16'hFFFF) && (lock_ff == `FSSP_LOCK_RST);
  endproperty
  a_erase_done: assert property (p_erase_done) else $error("erase left data");

  property p_ee_keep;
    @(posedge core_clk) disable iff (!rst_b)
    (erasing && keep_ee_ff) |-> !ee_erase ##1 (erasing || $fell(erasing));
  endproperty
  a_ee_keep: assert property (p_ee_keep) else $error("preserved eeprom erased");

  property p_pe_drop;
    @(posedge core_clk) disable iff (!rst_b)
    reset_pin_n |=> !pe_ff ##1 !cmd_ok;
  endproperty
  a_pe_drop: assert property (p_pe_drop) else $error("enable kept outside reset");

  property p_echo;
    @(posedge core_clk) disable iff (!rst_b)
    (byte_done && byte_idx == 2'h1) |-> tx_byte == rx_byte;
  endproperty
  a_echo: assert property (p_echo) else $error("second byte not echoed");

  property p_trim;
    @(posedge core_clk) disable iff (!rst_b)
    !reset_pin_n |=> oscillator_trim_register == `FSSP_CAL_BYTE;
  endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");
endmodule : fssp_core

// ===== sim/fssp_prog_model.sv
// Serial programmer model that drives the programming pins of the block.
`timescale 1ns/10ps
module fssp_prog_model (
  // Clock used to time the serial phases.
  input wire logic core_clk,
  // Programming pins.
  output logic reset_pin_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Pins start with reset high and the serial clock still.
  initial begin
    reset_pin_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Moves the reset pin, then lets the level settle before any frame.
  task automatic pin(input logic lvl);
    @(posedge core_clk);
    reset_pin_n <= lvl;
    repeat (4) @(posedge core_clk);
  endtask : pin

  // Shifts one frame MSB first; the low clock phase lasts five core cycles, the high phase six.
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    int i;
    for (i = 31; i >= 0; i--) begin
      @(posedge core_clk);
      sck <= 1'b0;
      mosi <= tx[i];
      repeat (5) @(posedge core_clk);
      rx[i] = miso;
      sck <= 1'b1;
      repeat (5) @(posedge core_clk);
    end
    @(posedge core_clk);
    sck <= 1'b0;
    mosi <= ~tx[0]; // The data line changes level once the frame is over.
  endtask : frame
endmodule : fssp_prog_model

// ===== sim/test_fuse_signature_serial_program_access.sv
// Self-checking bench for the fuse, signature and serial programming block.
`timescale 1ns/10ps
`include "fssp_cfg.svh"
module test_fuse_signature_serial_program_access;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reset_pin_n, sck, mosi, miso, miso_oe, prog_mode, nvm_busy, done;
  logic spe, ode, erd, eep, wao, wia, cd8;
  logic [1:0] bol, sts, css;
  logic [7:0] trim, cfg_hi, cfg_lo, dl, dh, de, df, ev;
  logic [7:0] sig [3] = '{`FSSP_SIG_BYTE0, `FSSP_SIG_BYTE1, `FSSP_SIG_BYTE2};
  logic [31:0] rng = 32'h00000010;
  logic [31:0] rx;
  int err_count = 0;
  int samples_checked = 0;
  int k;

  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;

  // Fuse outputs packed as the stored bytes, serial enable shown as zero.
  assign cfg_hi = {3'h7, spe, ode, bol, erd};
  assign cfg_lo = {1'h0, eep, wao, cd8, sts, css};

  fssp_core i_fssp_core (
    .core_clk(core_clk), .rst_b(rst_b), .reset_pin_n(reset_pin_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .cfg_self_program_enable(spe),
    .cfg_onchip_debug_enable(ode), .cfg_brownout_level(bol),
    .cfg_ext_reset_disable(erd), .cfg_eeprom_preserve(eep),
    .cfg_watchdog_always_on(wao), .watchdog_irq_allow(wia),
    .cfg_clock_divide_by_eight(cd8), .cfg_startup_time_sel(sts),
    .cfg_clock_source_sel(css), .oscillator_trim_register(trim),
    .prog_mode(prog_mode), .nvm_busy(nvm_busy));

  fssp_prog_model i_fssp_prog_model (
    .core_clk(core_clk), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso));

  // Next state of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Stored low fuse after a write; the serial enable bit cannot change.
  function automatic logic [7:0] lo_exp(input logic [7:0] d);
    return {1'h0, d[6:0]};
  endfunction : lo_exp

  // High fuse as seen on the outputs; the three unused bits read as one.
  function automatic logic [7:0] hi_exp(input logic [7:0] d);
    return {3'h7, d[4:0]};
  endfunction : hi_exp

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Sends one frame and keeps the reply.
  task automatic xfer(input logic [31:0] tx);
    i_fssp_prog_model.frame(tx, rx);
  endtask : xfer

  // Prints the verdict and ends the run.
  task automatic results;
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    rng = xs(rng);
    dl = rng[7:0];
    dh = rng[15:8] | 8'h01;
    de = rng[23:16];
    df = rng[31:24];
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(cfg_hi, 8'hFF, "high fuse defaults");
    check(cfg_lo, 8'h6A, "low fuse defaults");
    check({7'h00, wia}, 8'h01, "watchdog irq allowed");
    check(trim, `FSSP_CAL_BYTE, "trim after reset");
    i_fssp_prog_model.pin(1'b0);
    check({6'h00, prog_mode, miso_oe}, 8'h03, "programming entered");
    xfer(32'hACA80000);
    xfer(32'hAC530000);
    check(rx[15:8], 8'h53, "enable echo");
    xfer(32'h58080000);
    check(rx[7:0], 8'hFF, "write before enable ignored");
    for (k = 0; k < 3; k++) begin
      xfer({16'h3000, 6'h00, k[1:0], 8'h00});
      check(rx[7:0], sig[k], "signature byte");
    end
    xfer(32'h38000000);
    check(rx[7:0], `FSSP_CAL_BYTE, "calibration byte");
    xfer({24'hACA000, dl});
    xfer({24'hACA800, dh});
    xfer(32'h50000000);
    check(rx[7:0], lo_exp(dl), "low fuse readback");
    xfer(32'h58080000);
    check(rx[7:0], dh, "high fuse readback");
    check(cfg_hi, 8'hFF, "high fuse held in session");
    check(cfg_lo, {1'h0, dl[6], 6'h2A}, "preserve live, rest held");
    for (k = 0; k < 2; k++) begin
      ev = k[0] ? ~de : de;
      xfer({24'hC00025, ev});
      xfer(32'hA0002500);
      check(rx[7:0], ev, "eeprom rewrite");
    end
    xfer({24'h400005, df});
    xfer({24'h480005, ~df});
    xfer(32'h4C013000);
    xfer(32'h20013500);
    check(rx[7:0], df, "flash low byte");
    xfer(32'h28013500);
    check(rx[7:0], ~df, "flash high byte");
    xfer(32'hACE000FE);
    xfer(32'hACA80001);
    xfer(32'h58080000);
    check(rx[7:0], dh, "fuse locked");
    xfer(32'h30000000);
    check(rx[7:0], sig[0], "signature while locked");
    xfer(32'hAC800000);
    check({7'h00, nvm_busy}, 8'h01, "erase busy");
    done = 1'b0;
    for (k = 0; k < 20 && !done; k++) begin
      xfer(32'hF0000000);
      done = (rx[0] === 1'b0);
    end
    if (!done) begin
      err_count++;
      results();
    end
    xfer(32'h20013500);
    check(rx[7:0], 8'hFF, "flash erased");
    xfer(32'hA0002500);
    check(rx[7:0], dl[6] ? 8'hFF : ~de, "eeprom after erase");
    xfer(32'h50000000);
    check(rx[7:0], lo_exp(dl), "fuses survive erase");
    i_fssp_prog_model.pin(1'b1);
    check(cfg_hi, hi_exp(dh), "high fuse applied on exit");
    check(cfg_lo, lo_exp(dl), "low fuse applied on exit");
    check({7'h00, wia}, {7'h00, dl[5]}, "watchdog irq follows fuse");
    i_fssp_prog_model.pin(1'b0);
    xfer(32'hAC530000);
    xfer({24'hACA800, dh & 8'hFE});
    xfer({24'hACA000, dl & 8'hDF});
    i_fssp_prog_model.pin(1'b1);
    check(cfg_hi, hi_exp(dh & 8'hFE), "reset disable latched");
    check(cfg_lo, lo_exp(dl & 8'hDF), "low fuse second session");
    check({7'h00, wia}, 8'h00, "watchdog irq blocked");
    i_fssp_prog_model.pin(1'b0);
    check({6'h00, prog_mode, miso_oe}, 8'h00, "serial entry blocked");
    results();
  end
endmodule : test_fuse_signature_serial_program_access
